// file: rtl/mac_top.sv
// Purpose: mode based memory and register access checker
// Assumes: core presents one request per cycle, answer next cycle
// Notes: memory and register results are registered
`include "mac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mac_top
	import mac_pkg::*;
#(
	parameter int VA_W = `MAC_VA_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Mode sources
	input wire logic [7:0] status_word_high,
	input wire logic [1:0] mode_bits,
	input wire logic boot_done,
	// Core memory request
	input wire logic mem_req,
	input wire logic [1:0] mem_op,
	input wire logic [VA_W-1:0] mem_vaddr,
	input wire logic [7:0] mem_wdata,
	// Memory side
	output logic phy_req,
	output logic phy_we,
	output logic [`MAC_PA_W-1:0] phy_addr,
	output logic [7:0] phy_wdata,
	input wire logic [7:0] phy_rdata,
	// Core memory answer
	output logic mem_done,
	output logic mem_denied,
	output logic [7:0] mem_rdata,
	// Core register request
	input wire logic sfr_req,
	input wire logic sfr_we,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata_in,
	// Register side
	output logic sfr_wr_stb,
	output logic [7:0] sfr_wr_addr,
	output logic [7:0] sfr_wr_data,
	output logic [7:0] sfr_rdata,
	output logic sfr_denied,
	// Status
	output logic [1:0] mode_out,
	output logic boot_ram_on
);
	mac_mode_e mode;
	logic [7:0] fw_low_reg;
	logic [7:0] fw_high_reg;
	logic boot_reg;
	logic rd_pend_reg;
	logic [1:0] sel;
	logic [13:0] ofs;
	logic ok;
	logic [`MAC_PA_W-1:0] pa;
	mac_reg_if rq ();

	// ============================================================
	// Mode derivation
	always_comb begin
		if (mode_bits == 2'h0)
			mode = MAC_BOOT;
		else if (mode_bits == 2'h1)
			mode = MAC_TEST;
		else if (status_word_high[`MAC_STW_BIT])
			mode = MAC_RSTR;
		else
			mode = MAC_SYS;
	end

	// Boot RAM lives until boot ends; never reopens before reset
	always_ff @(posedge ref_clk) begin
		if (rst)
			boot_reg <= 1'b1;
		else if (boot_done)
			boot_reg <= 1'b0;
	end

	// ============================================================
	// Memory permission
	assign sel = mem_vaddr[`MAC_SEL_HI:`MAC_SEL_LO];
	assign ofs = mem_vaddr[`MAC_OFS_HI:0];

	function automatic logic in_lo(input logic [13:0] o,
		input logic [13:0] sz);
		in_lo = (o < sz);
	endfunction : in_lo

	always_comb begin
		ok = 1'b0;
		unique case (sel)
			`MAC_SEL_ROM: begin
				if (mem_op != MAC_OP_WR) begin
					unique case (mode)
						MAC_BOOT, MAC_RSTR: ok = in_lo(ofs, `MAC_TEST_ROM_SZ);
						MAC_TEST: ok = 1'b1;
						MAC_SYS: ok = !in_lo(ofs, `MAC_TEST_ROM_SZ);
					endcase
				end
			end
			`MAC_SEL_NVM: begin
				// Maker area at the bottom, then config partition
				unique case (mode)
					MAC_TEST: ok = 1'b1;
					MAC_BOOT, MAC_RSTR: ok = !in_lo(ofs, `MAC_MAKER_NVM_SZ)
						&& in_lo(ofs, `MAC_MAKER_NVM_SZ + `MAC_CFG_NVM_SZ);
					MAC_SYS: ok = !in_lo(ofs,
						`MAC_MAKER_NVM_SZ + `MAC_CFG_NVM_SZ);
				endcase
			end
			`MAC_SEL_RAM: begin
				if (mem_op != MAC_OP_EX) begin
					unique case (mode)
						MAC_BOOT: ok = boot_reg
							&& in_lo(ofs, `MAC_BOOT_RAM_SZ);
						MAC_TEST: ok = 1'b1;
						MAC_RSTR: ok = 1'b0;
						MAC_SYS: ok = !boot_reg
							|| !in_lo(ofs, `MAC_BOOT_RAM_SZ);
					endcase
				end
			end
			default: ok = 1'b0;
		endcase
	end

	// Virtual to physical translation
	always_comb begin
		unique case (sel)
			`MAC_SEL_NVM: pa = `MAC_PB_NVM + {2'h0, ofs};
			`MAC_SEL_RAM: pa = `MAC_PB_RAM + {2'h0, ofs};
			default: pa = `MAC_PB_ROM + {2'h0, ofs};
		endcase
	end

	// Issue only permitted accesses to the memory
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phy_req <= 1'b0;
			phy_we <= 1'b0;
			phy_addr <= '0;
			phy_wdata <= 8'h00;
		end else begin
			phy_req <= mem_req && ok;
			phy_we <= mem_req && ok && mem_op == MAC_OP_WR;
			phy_addr <= pa;
			phy_wdata <= mem_wdata;
		end
	end

	// Done and denied come with the issue, read data one cycle later; denied reads give zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mem_done <= 1'b0;
			mem_denied <= 1'b0;
			rd_pend_reg <= 1'b0;
			mem_rdata <= 8'h00;
		end else begin
			mem_done <= mem_req;
			mem_denied <= mem_req && !ok;
			rd_pend_reg <= mem_req && ok && mem_op != MAC_OP_WR;
			mem_rdata <= rd_pend_reg ? phy_rdata : 8'h00;
		end
	end

	// ============================================================
	// Register access
	assign rq.addr = sfr_addr;
	assign rq.mode = mode;
	assign rq.fw_ctrl = {fw_high_reg, fw_low_reg};

	mac_reg_perm u_perm (
		.q(rq)
	);

	// Firewall registers, reset closed
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fw_low_reg <= 8'h00;
			fw_high_reg <= 8'h00;
		end else if (sfr_req && sfr_we && rq.wr_ok) begin
			if (sfr_addr == `MAC_FWL_ADDR)
				fw_low_reg <= sfr_wdata;
			if (sfr_addr == `MAC_FWH_ADDR)
				fw_high_reg <= sfr_wdata;
		end
	end

	// Register read and write gating
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sfr_wr_stb <= 1'b0;
			sfr_wr_addr <= 8'h00;
			sfr_wr_data <= 8'h00;
			sfr_rdata <= 8'h00;
			sfr_denied <= 1'b0;
		end else begin
			sfr_wr_stb <= sfr_req && sfr_we && rq.wr_ok;
			sfr_wr_addr <= sfr_addr;
			sfr_wr_data <= sfr_wdata;
			sfr_rdata <= (sfr_req && !sfr_we && rq.rd_ok) ?
				sfr_rdata_in : 8'h00;
			sfr_denied <= sfr_req && (sfr_we ? !rq.wr_ok : !rq.rd_ok);
		end
	end

	// Status outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_out <= 2'h0;
			boot_ram_on <= 1'b1;
		end else begin
			mode_out <= mode;
			boot_ram_on <= boot_reg;
		end
	end
endmodule : mac_top
`default_nettype wire

// file: pkg/mac_cfg.svh
// Purpose: constants for the mode based access checker
// Assumes: byte addressed memories, 16-bit virtual address
// Notes: address map figures are plain defaults
// ============================================================
// What this block does
// - Mode from status word plus two bits
// - Core addresses are virtual, mapped to physical
// - Check permission before every memory access
// - Lowest 128 RAM bytes form boot RAM
// - Boot end: boot RAM zero, application maximal
// - 128 nonvolatile bytes always kept for maker
// - Refused register read returns zero
// - Refused register write is discarded
// - Restricted mode: firewall registers gate hardware
// - Registers refuse read and write together, never only one
// - Boot: read and fetch test ROM
// - Boot: full access to config nonvolatile partition
// - Boot: read and write boot RAM
// - Test: whole ROM, nonvolatile and RAM
// - Restricted mode: no RAM access
// - System: application ROM, nonvolatile, RAM
// - General CPU registers open in every mode
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH
// ============================================================
// Virtual map: region select in top two address bits
`define MAC_VA_W 16
`define MAC_PA_W 16
`define MAC_SEL_HI 15
`define MAC_SEL_LO 14
`define MAC_OFS_HI 13
`define MAC_SEL_ROM 2'h0
`define MAC_SEL_NVM 2'h1
`define MAC_SEL_RAM 2'h2
// Physical bases
`define MAC_PB_ROM 16'h0000
`define MAC_PB_NVM 16'h4000
`define MAC_PB_RAM 16'h8000
// Partition sizes in bytes
`define MAC_TEST_ROM_SZ 14'h0800
`define MAC_BOOT_RAM_SZ 14'h0080
`define MAC_MAKER_NVM_SZ 14'h0080
`define MAC_CFG_NVM_SZ 14'h0400
// Register groups: top three bits of an 8-bit register address
`define MAC_GRP_SYS 3'h0
`define MAC_GRP_FW 3'h1
`define MAC_GRP_TST 3'h2
`define MAC_GRP_HW 3'h3
`define MAC_GRP_CPU 3'h4
`define MAC_FWL_ADDR 8'h20
`define MAC_FWH_ADDR 8'h21
`define MAC_STW_BIT 3
`endif

// file: pkg/mac_pkg.sv
// Purpose: types for the mode based access checker
// Assumes: nothing
// Notes: modes Gray coded
package mac_pkg;
	typedef enum logic [1:0] {
		MAC_BOOT = 2'h0,
		MAC_TEST = 2'h1,
		MAC_SYS = 2'h3,
		MAC_RSTR = 2'h2
	} mac_mode_e;
	typedef enum logic [1:0] {
		MAC_OP_RD = 2'h0,
		MAC_OP_WR = 2'h1,
		MAC_OP_EX = 2'h3
	} mac_op_e;
endpackage : mac_pkg

// file: pkg/mac_reg_if.sv
// Purpose: register permission lookup channel
// Assumes: one clock
// Notes: combinational query
`timescale 1ns/1ps
`default_nettype none
interface mac_reg_if;
	import mac_pkg::*;
	logic [7:0] addr;
	mac_mode_e mode;
	logic [15:0] fw_ctrl;
	logic rd_ok;
	logic wr_ok;
	modport req (output addr, output mode, output fw_ctrl,
		input rd_ok, input wr_ok);
	modport rsp (input addr, input mode, input fw_ctrl,
		output rd_ok, output wr_ok);
endinterface : mac_reg_if
`default_nettype wire

// file: rtl/mac_reg_perm.sv
// Purpose: register access permission by group and mode
// Assumes: hardware group has 16 registers, one firewall bit each
// Notes: pure combinational
`include "mac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mac_reg_perm
	import mac_pkg::*;
(
	// Query
	mac_reg_if.rsp q
);
	logic [2:0] grp;
	assign grp = q.addr[7:5];
	// ============================================================
	// Group and mode decode
	always_comb begin
		q.rd_ok = 1'b0;
		q.wr_ok = 1'b0;
		if (grp == `MAC_GRP_CPU) begin
			q.rd_ok = 1'b1;
			q.wr_ok = 1'b1;
		end else if (q.mode == MAC_BOOT || q.mode == MAC_TEST) begin
			q.rd_ok = 1'b1;
			q.wr_ok = 1'b1;
		end else if (q.mode == MAC_SYS) begin
			// Test group stays closed outside boot and test
			q.rd_ok = (grp != `MAC_GRP_TST);
			q.wr_ok = (grp != `MAC_GRP_TST);
		end else begin
			if (grp == `MAC_GRP_FW) begin
				q.rd_ok = 1'b1;
				q.wr_ok = 1'b1;
			end else if (grp == `MAC_GRP_HW) begin
				// One firewall bit per register in the group
				q.rd_ok = q.fw_ctrl[q.addr[3:0]];
				q.wr_ok = q.fw_ctrl[q.addr[3:0]];
			end
		end
	end
endmodule : mac_reg_perm
`default_nettype wire

// file: dv/mac_far_model.sv
// Purpose: memories and register file behind the checker
// Assumes: reads answered in the request cycle
// Notes: a released read bus shows the inverted last byte
`timescale 1ns/1ps
`default_nettype none
// ====================
// Far side model
module mac_far_model (
	// Clock
	input wire logic ref_clk,
	// Memory side
	input wire logic phy_req,
	input wire logic phy_we,
	input wire logic [15:0] phy_addr,
	input wire logic [7:0] phy_wdata,
	output logic [7:0] phy_rdata,
	// Register side
	input wire logic sfr_wr_stb,
	input wire logic [7:0] sfr_wr_addr,
	input wire logic [7:0] sfr_wr_data,
	input wire logic [7:0] sfr_addr,
	output logic [7:0] sfr_rdata_in
);
	logic [7:0] mem [65536];
	logic [7:0] sfr [256];
	logic [7:0] last;
	// Patterned contents, so a wrong address shows
	initial begin
		last = 8'h00;
		for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
		for (int i = 0; i < 256; i++) sfr[i] = ~i[7:0];
	end
	// Writes land on the edge
	always @(posedge ref_clk) begin
		if (phy_req && phy_we) mem[phy_addr] <= phy_wdata;
		if (phy_req) last <= phy_rdata;
		if (sfr_wr_stb) sfr[sfr_wr_addr] <= sfr_wr_data;
	end
	// Idle bus never repeats the last byte
	assign phy_rdata = phy_req ? mem[phy_addr] : ~last;
	assign sfr_rdata_in = sfr[sfr_addr];
endmodule : mac_far_model
`default_nettype wire

// file: dv/mac_top_checker.sv
// Purpose: port checks for the access checker
// Assumes: answers one cycle after a request
// Notes: bound to mac_top below
`timescale 1ns/1ps
`default_nettype none
// ====================
// Checker
module mac_top_checker #(
	parameter int VA_W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Inputs
	input wire logic [7:0] status_word_high,
	input wire logic [1:0] mode_bits,
	input wire logic boot_done,
	input wire logic mem_req,
	input wire logic [1:0] mem_op,
	input wire logic [VA_W-1:0] mem_vaddr,
	input wire logic [7:0] phy_rdata,
	input wire logic sfr_req,
	input wire logic [7:0] sfr_addr,
	// Outputs
	input wire logic phy_req,
	input wire logic mem_denied,
	input wire logic [7:0] mem_rdata,
	input wire logic sfr_wr_stb,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_denied,
	input wire logic [1:0] mode_out,
	input wire logic boot_ram_on
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Granted read, then its data
	sequence s_rd_ok;
		mem_req && mem_op == 2'h0 ##1 phy_req;
	endsequence
	// Restricted inputs held two edges
	sequence s_rstr;
		(mode_bits[1] && status_word_high[3]) [*2];
	endsequence
	AST_MODE: assert property (s_rstr |-> mode_out == 2'h2)
		else $error("mode not restricted");
	AST_RDATA: assert property (
		s_rd_ok |=> mem_rdata == $past(phy_rdata))
		else $error("read data not passed");
	AST_UNMAP: assert property (
		mem_req && mem_vaddr[15:14] == 2'h3 |=> mem_denied && !phy_req)
		else $error("unmapped access granted");
	AST_RDZERO: assert property (
		mem_denied |=> mem_rdata == 8'h00)
		else $error("refused read not zero");
	AST_RSTR_RAM: assert property (
		mem_req && mem_vaddr[15:14] == 2'h2 && mode_out == 2'h2
		&& mode_bits[1] && status_word_high[3] |=> mem_denied)
		else $error("RAM open in restricted mode");
	AST_SFR_DENY: assert property (
		sfr_denied |-> sfr_rdata == 8'h00 && !sfr_wr_stb)
		else $error("refused register access leaked");
	AST_CPU: assert property (
		sfr_req && sfr_addr[7:5] == 3'h4 |=> !sfr_denied)
		else $error("CPU register refused");
	// Flag drops on the first edge, status output on the next
	AST_BOOT_END: assert property (boot_done |-> ##2 !boot_ram_on)
		else $error("boot RAM still open");
endmodule : mac_top_checker
bind mac_top mac_top_checker #(.VA_W(VA_W)) mac_top_checker_i (.ref_clk,
	.rst, .status_word_high, .mode_bits, .boot_done, .mem_req, .mem_op,
	.mem_vaddr, .phy_rdata, .sfr_req, .sfr_addr, .phy_req, .mem_denied,
	.mem_rdata, .sfr_wr_stb, .sfr_rdata, .sfr_denied, .mode_out,
	.boot_ram_on);
`default_nettype wire

// file: dv/test_mac_top.sv
// Purpose: self-checking bench for the access checker
// Assumes: far side model answers reads at once
// Notes: mode code is {status bit, mode_bits}
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
	$display("FAIL %0t %h %h", $time, a, b); failures++; end end
// ====================
// Bench
module test_mac_top;
	logic ref_clk, rst, boot_done, mem_req, phy_req, phy_we, mem_done;
	logic mem_denied, sfr_req, sfr_we, sfr_wr_stb, sfr_denied, boot_ram_on;
	logic [1:0] mode_bits, mem_op, mode_out;
	logic [15:0] mem_vaddr, phy_addr;
	logic [7:0] status_word_high, mem_wdata, phy_wdata, phy_rdata, mem_rdata;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_in, sfr_wr_addr, sfr_wr_data;
	logic [7:0] sfr_rdata;
	int failures = 0;
	int cmp_count = 0;
	mac_top mac_top_i (.ref_clk, .rst, .status_word_high, .mode_bits,
		.boot_done, .mem_req, .mem_op, .mem_vaddr, .mem_wdata, .phy_req,
		.phy_we, .phy_addr, .phy_wdata, .phy_rdata, .mem_done, .mem_denied,
		.mem_rdata, .sfr_req, .sfr_we, .sfr_addr, .sfr_wdata, .sfr_rdata_in,
		.sfr_wr_stb, .sfr_wr_addr, .sfr_wr_data, .sfr_rdata, .sfr_denied,
		.mode_out, .boot_ram_on);
	mac_far_model mac_far_model_i (.ref_clk, .phy_req, .phy_we, .phy_addr,
		.phy_wdata, .phy_rdata, .sfr_wr_stb, .sfr_wr_addr, .sfr_wr_data,
		.sfr_addr, .sfr_rdata_in);
	// Mode set early so the registered mode settles
	task automatic setm(input logic [2:0] md);
		@(posedge ref_clk);
		#1;
		mode_bits = md[1:0];
		status_word_high = {4'h0, md[2], 3'h0};
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(mode_out, md[1] ? {1'b1, ~md[2]} : md[1:0])
	endtask : setm
	// One memory access, judged against the model
	task automatic acc(input logic [2:0] md, input logic [1:0] op,
		input logic [15:0] va, input logic ok);
		logic [7:0] old;
		setm(md);
		old = mac_far_model_i.mem[va];
		mem_req = 1'b1;
		mem_op = op;
		mem_vaddr = va;
		@(posedge ref_clk);
		#1;
		mem_req = 1'b0;
		`CHK(mem_denied, !ok)
		`CHK(mem_done, 1'b1)
		`CHK(phy_req, ok)
		// Region bases sit at select times 16K, so mapped pa equals va
		if (ok) `CHK(phy_addr, va)
		@(posedge ref_clk);
		#1;
		`CHK(mem_rdata, (ok && op != 2'h1) ? old : 8'h00)
		`CHK(mac_far_model_i.mem[va], (ok && op == 2'h1) ? 8'h5a : old)
	endtask : acc
	// One register access
	task automatic reg_acc(input logic [2:0] md, input logic we,
		input logic [7:0] a, input logic ok);
		setm(md);
		sfr_req = 1'b1;
		sfr_we = we;
		sfr_addr = a;
		@(posedge ref_clk);
		#1;
		sfr_req = 1'b0;
		`CHK(sfr_denied, !ok)
		`CHK(sfr_wr_stb, ok && we)
		if (we) `CHK({sfr_wr_addr, sfr_wr_data}, {a, sfr_wdata})
		if (!we) `CHK(sfr_rdata, ok ? mac_far_model_i.sfr[a] : 8'h00)
	endtask : reg_acc
	task automatic wrap_up();
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Hang guard, about 70 times the expected run
	initial begin
		#1000000;
		failures++;
		wrap_up();
	end
	initial begin
		{rst, boot_done, mem_req, sfr_req, sfr_we, mem_op} = 7'h40;
		{mode_bits, status_word_high, mem_vaddr, sfr_addr} = '0;
		mem_wdata = 8'h5a;
		sfr_wdata = 8'h01;
		repeat (8) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		`CHK(boot_ram_on, 1'b1)
		acc(3'h0, 2'h0, 16'h0010, 1'b1);
		acc(3'h0, 2'h3, 16'h07ff, 1'b1);
		acc(3'h0, 2'h0, 16'h0800, 1'b0);
		acc(3'h0, 2'h1, 16'h0020, 1'b0);
		acc(3'h0, 2'h1, 16'h4100, 1'b1);
		acc(3'h0, 2'h0, 16'h407f, 1'b0);
		acc(3'h0, 2'h1, 16'h807f, 1'b1);
		acc(3'h0, 2'h0, 16'h8080, 1'b0);
		acc(3'h0, 2'h0, 16'hc000, 1'b0);
		acc(3'h1, 2'h3, 16'h1000, 1'b1);
		acc(3'h1, 2'h1, 16'h4010, 1'b1);
		acc(3'h6, 2'h0, 16'h8010, 1'b0);
		acc(3'h6, 2'h1, 16'h4100, 1'b1);
		acc(3'h2, 2'h0, 16'h0010, 1'b0);
		acc(3'h3, 2'h1, 16'h4800, 1'b1);
		acc(3'h3, 2'h0, 16'h8100, 1'b1);
		acc(3'h3, 2'h0, 16'h8010, 1'b0);
		boot_done = 1'b1;
		@(posedge ref_clk);
		#1;
		boot_done = 1'b0;
		// Status output trails the internal boot flag by one edge
		@(posedge ref_clk);
		#1;
		`CHK(boot_ram_on, 1'b0)
		acc(3'h3, 2'h0, 16'h8010, 1'b1);
		acc(3'h0, 2'h1, 16'h8010, 1'b0);
		acc(3'h3, 2'h3, 16'h8010, 1'b0);
		reg_acc(3'h6, 1'b1, 8'h20, 1'b1);
		reg_acc(3'h6, 1'b0, 8'h60, 1'b1);
		reg_acc(3'h6, 1'b1, 8'h61, 1'b0);
		reg_acc(3'h6, 1'b1, 8'h21, 1'b1);
		reg_acc(3'h6, 1'b0, 8'h68, 1'b1);
		reg_acc(3'h1, 1'b0, 8'h40, 1'b1);
		reg_acc(3'h6, 1'b0, 8'h80, 1'b1);
		reg_acc(3'h3, 1'b0, 8'h40, 1'b0);
		reg_acc(3'h3, 1'b0, 8'ha0, 1'b1);
		wrap_up();
	end
endmodule : test_mac_top
`default_nettype wire
